// File: opsh_pkg.sv
// shared constants and types for the operand shifter datapath
package opsh_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_OPA    = 8'h04;
  localparam logic [7:0] OFS_SRC    = 8'h08;
  localparam logic [7:0] OFS_AMT    = 8'h0C;
  localparam logic [7:0] OFS_PC     = 8'h10;
  localparam logic [7:0] OFS_CUR    = 8'h14;
  localparam logic [7:0] OFS_SAVED  = 8'h18;
  localparam logic [7:0] OFS_CTRL   = 8'h1C;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_OP2    = 8'h24;
  localparam logic [7:0] OFS_STAT   = 8'h28;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_CUR  = 32'h0000_00D3;

  // control and execution status field positions
  localparam int CTRL_GO    = 0;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_SHC     = 2;
  localparam int ST_RDWR    = 3;
  localparam int ST_PCWR    = 4;
  localparam int ST_UNDEF   = 5;
  localparam int ST_BADRS   = 6;
  localparam int ST_SCNT    = 8;
  localparam int ST_NCNT    = 10;
  localparam int ST_ICNT    = 12;

  // status word flag positions and mode field
  localparam int FLAG_N = 31;
  localparam int FLAG_Z = 30;
  localparam int FLAG_C = 29;
  localparam int FLAG_V = 28;
  localparam logic [4:0] MODE_USER = 5'h10;

  // instruction fields
  localparam int BIT_IMM    = 25;
  localparam int BIT_SETF   = 20;
  localparam int BIT_REGSH  = 4;
  localparam int BIT_MULSEL = 7;
  localparam logic [3:0] PC_INDEX = 4'hF;

  // program counter prefetch offsets
  localparam logic [31:0] PC_AHEAD_IMM = 32'h0000_0008;
  localparam logic [31:0] PC_AHEAD_REG = 32'h0000_000C;

  // cycle counts per class
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_NONE = 2'h0;

  typedef enum logic [1:0] {
    SH_LEFT_LOGICAL  = 2'h0,
    SH_RIGHT_LOGICAL = 2'h1,
    SH_RIGHT_SIGNED  = 2'h2,
    SH_ROTATE_RIGHT  = 2'h3
  } shift_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_FIN  = 3'b100
  } state_t;

endpackage

// File: operand_shifter.sv
// barrel shifter and rotated immediate for the second operand
`timescale 1ns/1ps
module operand_shifter (
  input  wire logic              i_imm_op,
  input  wire logic              i_reg_amt,
  input  wire opsh_pkg::shift_kind_t i_type,
  input  wire logic [4:0]        i_imm_amt,
  input  wire logic [7:0]        i_reg_byte,
  input  wire logic [3:0]        i_rot,
  input  wire logic [7:0]        i_imm8,
  input  wire logic [31:0]       i_src,
  input  wire logic              i_carry,
  output logic      [31:0]       o_op2,
  output logic                   o_carry
);
  import opsh_pkg::*;

  logic [8:0]  n;
  logic [32:0] sh33;
  logic [63:0] dbl;
  logic        rot_ext;

  // purely combinational so the ALU sees the operand in the same cycle
  always_comb begin
    n    = 9'h000;
    sh33 = 33'h0_0000_0000;
    dbl  = 64'h0;
    rot_ext = 1'b0;
    o_op2   = i_src;
    o_carry = i_carry;
    if (i_reg_amt) begin
      n = {1'b0, i_reg_byte};
    end else if (i_imm_amt == 5'h00 && i_type != SH_LEFT_LOGICAL) begin
      n       = 9'h020;
      rot_ext = (i_type == SH_ROTATE_RIGHT);
    end else begin
      n = {4'h0, i_imm_amt};
    end
    unique case (i_type)
      SH_LEFT_LOGICAL: begin
        sh33    = {1'b0, i_src} << n;
        o_op2   = sh33[31:0];
        o_carry = sh33[32];
      end
      SH_RIGHT_LOGICAL: begin
        sh33    = {i_src, 1'b0} >> n;
        o_op2   = sh33[32:1];
        o_carry = sh33[0];
      end
      SH_RIGHT_SIGNED: begin
        if (n >= 9'h020) begin
          o_op2   = {32{i_src[31]}};
          o_carry = i_src[31];
        end else begin
          sh33    = $signed({i_src, 1'b0}) >>> n;
          o_op2   = sh33[32:1];
          o_carry = sh33[0];
        end
      end
      SH_ROTATE_RIGHT: begin
        // amounts above 32 fold by taking the low five bits
        dbl     = {i_src, i_src} >> n[4:0];
        o_op2   = dbl[31:0];
        o_carry = dbl[31];
        if (rot_ext) begin
          o_op2   = {i_carry, i_src[31:1]};
          o_carry = i_src[0];
        end
      end
    endcase
    // a zero amount passes the source and the old carry; by reuse
    if (n == 9'h000) begin
      o_op2   = i_src;
      o_carry = i_carry;
    end
    if (i_imm_op) begin
      dbl     = {24'h0, i_imm8, 24'h0, i_imm8} >> {i_rot, 1'b0};
      o_op2   = dbl[31:0];
      o_carry = (i_rot == 4'h0) ? i_carry : dbl[31];
    end
  end

endmodule

// File: operand_shifter_datapath.sv
// execute-stage operand shifter, ALU and write-back behind Avalon-MM
// Notes on behaviour
// - immediate left shift by zero passes source, carry keeps old flag
// - immediate right shift field zero means shift by 32, carry bit 31
// - arithmetic right shift fills vacated upper bits with bit 31
// - immediate arithmetic field zero shifts by 32, all bits equal bit 31
// - rotate right feeds low bits shifted out back into the top
// - immediate rotate field zero rotates carry-over-source by one
// - register amount uses low byte only; amount register not the PC
// - register amount zero passes source and old carry unchanged
// - register amounts 1 to 31 match the immediate form exactly
// - register left shift 32 gives zero, carry bit 0; above, carry 0
// - register right shift 32 gives zero, carry bit 31; above, carry 0
// - register arithmetic shift 32 or more fills with bit 31
// - register rotate 32 returns source, carry bit 31; larger folds
// - register shift needs bit 7 zero; else multiply or undefined
// - immediate is eight bits zero-extended, rotated by twice the field
// - PC destination without set-flags writes PC, status untouched
// - PC destination with set-flags writes PC and restores saved status
// - PC as operand reads address plus 8, or plus 12 with register shift
// - compare and test ops only update flags, write no destination
// - legacy status test form copies saved status only when privileged
// - cycles: 1S, 1S+1I, 2S+1N, 2S+1N+1I per class
// - logical ops with set-flags take shifter carry into carry flag
`timescale 1ns/1ps
module operand_shifter_datapath (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic             o_busy
);
  import opsh_pkg::*;
  default clocking cb_main @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] opa;
    logic [31:0] src;
    logic [31:0] amt;
    logic [31:0] pc;
    logic [31:0] cur;
    logic [31:0] saved;
    logic [31:0] result;
    logic [31:0] op2;
    logic [31:0] rdata;
    logic        waitreq;
    state_t      state;
    logic        busy;
    logic [2:0]  left;
    logic        shc;
    logic        rd_wr;
    logic        pc_wr;
    logic        undef;
    logic        amt_pc;
    logic [1:0]  s_cnt;
    logic [1:0]  n_cnt;
    logic [1:0]  i_cnt;
  } regs_t;

  regs_t core_reg;
  regs_t core_next;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // instruction fields
  logic [3:0]  opcode;
  logic [3:0]  rn;
  logic [3:0]  rd;
  logic [3:0]  amt_idx;
  logic [3:0]  src_idx;
  logic        imm_op;
  logic        setf;
  logic        reg_sh;
  logic        is_test;
  logic        is_logic;
  logic [31:0] pc_eff;
  logic [31:0] a_val;
  logic [31:0] src_eff;
  logic [31:0] op2;
  logic        sh_carry;
  logic [31:0] x;
  logic [31:0] y;
  logic        ci;
  logic [32:0] sum;
  logic [31:0] alu;
  logic        alu_c;
  logic        alu_v;
  logic        req;
  logic        commit;
  logic        launch;
  logic        undef_dec;
  logic        amt_pc_dec;
  logic        legal;
  logic        privileged;
  logic        pc_dest;

  assign opcode  = core_reg.instr[24:21];
  assign rn      = core_reg.instr[19:16];
  assign rd      = core_reg.instr[15:12];
  assign amt_idx = core_reg.instr[11:8];
  assign src_idx = core_reg.instr[3:0];
  assign imm_op  = core_reg.instr[BIT_IMM];
  assign setf    = core_reg.instr[BIT_SETF];
  assign reg_sh  = !imm_op && core_reg.instr[BIT_REGSH];
  assign is_test = (opcode[3:2] == 2'b10);
  assign is_logic = (opcode[3:1] == 3'b000) || (opcode[3:1] == 3'b100) ||
                    (opcode[3:2] == 2'b11);
  assign pc_eff  = core_reg.pc + (reg_sh ? PC_AHEAD_REG : PC_AHEAD_IMM);
  assign a_val   = (rn == PC_INDEX) ? pc_eff : core_reg.opa;
  assign src_eff = (src_idx == PC_INDEX) ? pc_eff : core_reg.src;
  assign undef_dec  = reg_sh && core_reg.instr[BIT_MULSEL];
  assign amt_pc_dec = reg_sh && (amt_idx == PC_INDEX);
  assign legal      = !undef_dec && !amt_pc_dec;
  assign privileged = (core_reg.cur[4:0] != MODE_USER);
  assign pc_dest    = (rd == PC_INDEX);
  assign req    = i_read || i_write;
  assign commit = req && !core_reg.waitreq;
  assign launch = commit && i_write && (i_address == OFS_CTRL) &&
                  i_byteenable[0] && i_writedata[CTRL_GO] &&
                  (core_reg.state != ST_EXEC);

  operand_shifter operand_shifter_i (
    .i_imm_op   (imm_op),
    .i_reg_amt  (reg_sh),
    .i_type     (shift_kind_t'(core_reg.instr[6:5])),
    .i_imm_amt  (core_reg.instr[11:7]),
    .i_reg_byte (core_reg.amt[7:0]),
    .i_rot      (core_reg.instr[11:8]),
    .i_imm8     (core_reg.instr[7:0]),
    .i_src      (src_eff),
    .i_carry    (core_reg.cur[FLAG_C]),
    .o_op2      (op2),
    .o_carry    (sh_carry)
  );

  // ALU; subtraction is addition of the inverted operand plus carry
  always_comb begin
    x  = a_val;
    y  = op2;
    if (opcode == 4'h3 || opcode == 4'h7) begin
      x = op2;
      y = ~a_val;
    end else if (opcode == 4'h2 || opcode == 4'h6 || opcode == 4'hA) begin
      y = ~op2;
    end
    unique case (opcode)
      4'h2, 4'h3, 4'hA: ci = 1'b1;
      4'h5, 4'h6, 4'h7: ci = core_reg.cur[FLAG_C];
      default: ci = 1'b0;
    endcase
    sum   = {1'b0, x} + {1'b0, y} + {32'h0, ci};
    alu_v = (x[31] == y[31]) && (sum[31] != x[31]);
    alu_c = sum[32];
    unique case (opcode)
      4'h0, 4'h8: alu = a_val & op2;
      4'h1, 4'h9: alu = a_val ^ op2;
      4'hC: alu = a_val | op2;
      4'hD: alu = op2;
      4'hE: alu = a_val & ~op2;
      4'hF: alu = ~op2;
      default: alu = sum[31:0];
    endcase
  end

  always_comb begin
    core_next = core_reg;
    // one wait cycle per access; read data loads on the edge that drops waitrequest, write data lands at the low edge
    if (req && core_reg.waitreq) begin
      core_next.waitreq = 1'b0;
      core_next.rdata   = 32'h0000_0000;
      if (i_read) begin
        unique case (i_address)
          OFS_INSTR:  core_next.rdata = core_reg.instr;
          OFS_OPA:    core_next.rdata = core_reg.opa;
          OFS_SRC:    core_next.rdata = core_reg.src;
          OFS_AMT:    core_next.rdata = core_reg.amt;
          OFS_PC:     core_next.rdata = core_reg.pc;
          OFS_CUR:    core_next.rdata = core_reg.cur;
          OFS_SAVED:  core_next.rdata = core_reg.saved;
          OFS_RESULT: core_next.rdata = core_reg.result;
          OFS_OP2:    core_next.rdata = core_reg.op2;
          OFS_STAT: begin
            core_next.rdata[ST_BUSY]  = (core_reg.state == ST_EXEC);
            core_next.rdata[ST_DONE]  = (core_reg.state == ST_FIN);
            core_next.rdata[ST_SHC]   = core_reg.shc;
            core_next.rdata[ST_RDWR]  = core_reg.rd_wr;
            core_next.rdata[ST_PCWR]  = core_reg.pc_wr;
            core_next.rdata[ST_UNDEF] = core_reg.undef;
            core_next.rdata[ST_BADRS] = core_reg.amt_pc;
            core_next.rdata[ST_SCNT +: 2] = core_reg.s_cnt;
            core_next.rdata[ST_NCNT +: 2] = core_reg.n_cnt;
            core_next.rdata[ST_ICNT +: 2] = core_reg.i_cnt;
          end
          default: core_next.rdata = 32'h0000_0000;
        endcase
      end
    end else if (commit) begin
      core_next.waitreq = 1'b1;
      if (i_write) begin
        unique case (i_address)
          OFS_INSTR: core_next.instr =
            be_merge(core_reg.instr, i_writedata, i_byteenable);
          OFS_OPA: core_next.opa =
            be_merge(core_reg.opa, i_writedata, i_byteenable);
          OFS_SRC: core_next.src =
            be_merge(core_reg.src, i_writedata, i_byteenable);
          OFS_AMT: core_next.amt =
            be_merge(core_reg.amt, i_writedata, i_byteenable);
          OFS_PC: core_next.pc =
            be_merge(core_reg.pc, i_writedata, i_byteenable);
          OFS_CUR: core_next.cur =
            be_merge(core_reg.cur, i_writedata, i_byteenable);
          OFS_SAVED: core_next.saved =
            be_merge(core_reg.saved, i_writedata, i_byteenable);
          default: core_next.waitreq = 1'b1;
        endcase
      end
    end

    unique case (core_reg.state)
      ST_IDLE, ST_FIN: begin
        if (launch) begin
          core_next.op2    = op2;
          core_next.shc    = sh_carry;
          core_next.undef  = undef_dec;
          core_next.amt_pc = amt_pc_dec;
          core_next.rd_wr  = 1'b0;
          core_next.pc_wr  = 1'b0;
          core_next.s_cnt  = CYC_NONE;
          core_next.n_cnt  = CYC_NONE;
          core_next.i_cnt  = CYC_NONE;
          core_next.left   = 3'h0;
          core_next.state  = ST_FIN;
          if (legal) begin
            core_next.state = ST_EXEC;
            core_next.s_cnt = CYC_ONE;
            core_next.i_cnt = reg_sh ? CYC_ONE : CYC_NONE;
            if (is_test && pc_dest) begin
              if (privileged) begin
                core_next.cur = core_reg.saved;
              end
            end else if (is_test || !pc_dest) begin
              core_next.rd_wr = !is_test;
              if (!is_test) begin
                core_next.result = alu;
              end
              if (setf) begin
                core_next.cur[FLAG_N] = alu[31];
                core_next.cur[FLAG_Z] = (alu == 32'h0000_0000);
                if (is_logic) begin
                  core_next.cur[FLAG_C] = sh_carry;
                end else begin
                  core_next.cur[FLAG_C] = alu_c;
                  core_next.cur[FLAG_V] = alu_v;
                end
              end
            end else begin
              core_next.pc    = alu;
              core_next.pc_wr = 1'b1;
              core_next.s_cnt = CYC_TWO;
              core_next.n_cnt = CYC_ONE;
              if (setf) begin
                core_next.cur = core_reg.saved;
              end
            end
            // busy for S+N+I cycles, counted down to zero
            core_next.left = 3'({1'b0, core_next.s_cnt} +
                                {1'b0, core_next.n_cnt} +
                                {1'b0, core_next.i_cnt} - 3'h1);
          end
        end
      end
      ST_EXEC: begin
        if (core_reg.left == 3'h0) begin
          core_next.state = ST_FIN;
        end else begin
          core_next.left = core_reg.left - 3'h1;
        end
      end
    endcase
    // registered copy so the busy pin comes straight from a flop
    core_next.busy = (core_next.state == ST_EXEC);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      core_reg         <= '0;
      core_reg.cur     <= RST_CUR;
      core_reg.waitreq <= 1'b1;
      core_reg.state   <= ST_IDLE;
    end else begin
      core_reg <= core_next;
    end
  end

  assign o_readdata    = core_reg.rdata;
  assign o_waitrequest = core_reg.waitreq;
  assign o_busy        = core_reg.busy;

  logic imm_sh;
  assign imm_sh = !imm_op && !core_reg.instr[BIT_REGSH];

  a_left_zero_pass: assert property (launch && imm_sh &&
    core_reg.instr[11:5] == 7'h00 |=> core_reg.op2 == $past(src_eff) &&
    core_reg.shc == $past(core_reg.cur[FLAG_C]))
    else $error("left shift zero did not pass source and carry");
  a_right_imm_32: assert property (launch && imm_sh &&
    core_reg.instr[11:5] == 7'h01 |=> core_reg.op2 == 32'h0000_0000 &&
    core_reg.shc == $past(src_eff[31]))
    else $error("right shift field zero is not a shift by 32");
  a_signed_imm_32: assert property (launch && imm_sh &&
    core_reg.instr[11:5] == 7'h02 |=>
    core_reg.op2 == {32{$past(src_eff[31])}} &&
    core_reg.shc == $past(src_eff[31]))
    else $error("arithmetic shift field zero is not a fill by 32");
  a_extend_form: assert property (launch && imm_sh &&
    core_reg.instr[11:5] == 7'h03 |=>
    core_reg.op2 == {$past(core_reg.cur[FLAG_C]), $past(src_eff[31:1])} &&
    core_reg.shc == $past(src_eff[0]))
    else $error("extended rotate wrong");
  a_reg_amt_zero: assert property (launch && reg_sh &&
    core_reg.amt[7:0] == 8'h00 |=> core_reg.op2 == $past(src_eff) &&
    core_reg.shc == $past(core_reg.cur[FLAG_C]))
    else $error("register amount zero altered operand");
  a_left_reg_32: assert property (launch && reg_sh &&
    core_reg.instr[6:5] == 2'h0 && core_reg.amt[7:0] == 8'h20 |=>
    core_reg.op2 == 32'h0000_0000 && core_reg.shc == $past(src_eff[0]))
    else $error("register left shift by 32 wrong");
  a_imm_rotate: assert property (launch && imm_op &&
    core_reg.instr[11:8] == 4'h1 |=> core_reg.op2 ==
    {$past(core_reg.instr[1:0]), 24'h000000, $past(core_reg.instr[7:2])})
    else $error("rotated immediate wrong");
  a_pc_no_flags: assert property (launch && legal && pc_dest &&
    !setf && !is_test |=> core_reg.pc == $past(alu) &&
    core_reg.cur == $past(core_reg.cur))
    else $error("program counter write disturbed status");
  a_test_no_write: assert property (launch && legal && is_test |=>
    core_reg.result == $past(core_reg.result) && !core_reg.rd_wr)
    else $error("test op wrote a destination");
  a_cycle_full: assert property (launch && legal && reg_sh &&
    pc_dest && !is_test |=> o_busy [*4] ##1 !o_busy)
    else $error("register shift with pc write not four cycles");

endmodule

// File: test_operand_shifter_datapath.sv
// self-checking bench for the operand shifter datapath
`timescale 1ns/1ps
module test_operand_shifter_datapath;
  import opsh_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [7:0]  i_address = 8'h00;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0000_0000;
  logic [3:0]  i_byteenable = 4'hF;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        o_busy;
  logic [31:0] res, op2, st, cu, pcv, q;
  int          err_total = 0;
  int          checked = 0;
  int          bcnt;

  operand_shifter_datapath operand_shifter_datapath_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_busy(o_busy));

  always #10 i_clk = ~i_clk;

  task automatic complete_run();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one edge of gap first, so a release and a new request never collide
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge i_clk);
    i_address   <= a;
    i_write     <= wr;
    i_read      <= ~wr;
    i_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 100);
    q = o_readdata;
    i_write <= 1'b0;
    i_read  <= 1'b0;
    chk(n < 100, 1);
  endtask

  task automatic exec(input logic [31:0] ins, input logic [31:0] src_v,
                      input logic [31:0] amt_v, input logic [31:0] cur,
                      input logic [31:0] sav);
    int n = 0;
    bus(1'b1, OFS_INSTR, ins);
    bus(1'b1, OFS_OPA, 32'h0000_00F0);
    bus(1'b1, OFS_SRC, src_v);
    bus(1'b1, OFS_AMT, amt_v);
    bus(1'b1, OFS_PC, 32'h0000_0100);
    bus(1'b1, OFS_CUR, cur);
    bus(1'b1, OFS_SAVED, sav);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    bcnt = 0;
    repeat (6) begin
      @(posedge i_clk);
      if (o_busy === 1'b1) bcnt++;
    end
    do begin
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      n++;
    end while (q[ST_DONE] !== 1'b1 && n < 20);
    st = q;
    chk(st[ST_DONE], 1'b1);
    bus(1'b0, OFS_RESULT, 32'h0000_0000);
    res = q;
    bus(1'b0, OFS_OP2, 32'h0000_0000);
    op2 = q;
    bus(1'b0, OFS_CUR, 32'h0000_0000);
    cu = q;
    bus(1'b0, OFS_PC, 32'h0000_0000);
    pcv = q;
  endtask

  // independent reference: amounts above 32 handled per shift type
  function automatic logic [32:0] model(input logic [31:0] s,
      input logic [1:0] t, input logic rg, input logic [7:0] a,
      input logic c);
    logic [7:0]  n;
    logic [63:0] w;
    n = a;
    if (n == 8'h00 && (rg || t == 2'h0)) return {c, s};
    if (n == 8'h00 && t == 2'h3) return {s[0], c, s[31:1]};
    if (n == 8'h00) n = 8'h20;
    case (t)
      2'h0: begin
        w = {32'h0000_0000, s} << n;
        return {w[32], w[31:0]};
      end
      2'h1: begin
        w = {s, 32'h0000_0000} >> n;
        return {(n > 8'h20) ? 1'b0 : w[31], w[63:32]};
      end
      2'h2: begin
        w = $signed({s, 32'h0000_0000}) >>> ((n > 8'h20) ? 8'h20 : n);
        return {w[31], w[63:32]};
      end
      default: begin
        w = {s, s} >> n[4:0];
        return {w[31], w[31:0]};
      end
    endcase
  endfunction

  task automatic shcase(input logic [1:0] t, input logic rg,
                        input logic [7:0] a, input logic [31:0] s,
                        input logic c);
    logic [32:0] e;
    logic [31:0] ins;
    e = model(s, t, rg, a, c);
    ins = rg ? {20'hE1B01, 4'h4, 1'b0, t, 1'b1, 4'h2}
             : {20'hE1B01, a[4:0], t, 1'b0, 4'h2};
    exec(ins, s, {24'h123456, a}, {2'b00, c, 29'h0D3}, 32'h0000_0000);
    chk(op2, e[31:0]);
    chk(res, e[31:0]);
    chk(st[ST_SHC], e[32]);
    chk(cu[FLAG_C], e[32]);
    chk(bcnt, rg ? 2 : 1);
  endtask

  task automatic immc(input logic [3:0] r, input logic [7:0] v,
                      input logic c);
    logic [63:0] w;
    w = {24'h000000, v, 24'h000000, v} >> {r, 1'b0};
    exec({20'hE3B01, r, v}, 32'h0000_0000, 32'h0000_0000,
         {2'b00, c, 29'h0D3}, 32'h0000_0000);
    chk(op2, w[31:0]);
    chk(st[ST_SHC], (r == 4'h0) ? c : w[31]);
  endtask

  task automatic shift_tests();
    shcase(2'h0, 1'b0, 8'h00, 32'h8000_0001, 1'b1);
    shcase(2'h1, 1'b0, 8'h00, 32'h8000_0001, 1'b0);
    shcase(2'h2, 1'b0, 8'h05, 32'h80F0_0000, 1'b0);
    shcase(2'h2, 1'b0, 8'h00, 32'h8000_0000, 1'b0);
    shcase(2'h2, 1'b0, 8'h00, 32'h7FFF_FFFF, 1'b1);
    shcase(2'h3, 1'b0, 8'h05, 32'h0000_0031, 1'b0);
    shcase(2'h3, 1'b0, 8'h00, 32'h0000_0003, 1'b1);
    shcase(2'h0, 1'b1, 8'h00, 32'h8000_0001, 1'b1);
    for (int t = 0; t < 4; t++)
      shcase(t[1:0], 1'b1, 8'h05, 32'h9000_0031, 1'b0);
    shcase(2'h0, 1'b1, 8'h20, 32'h0000_0001, 1'b0);
    shcase(2'h0, 1'b1, 8'h21, 32'hFFFF_FFFF, 1'b1);
    shcase(2'h1, 1'b1, 8'h20, 32'h8000_0000, 1'b0);
    shcase(2'h1, 1'b1, 8'h28, 32'hFFFF_FFFF, 1'b1);
    shcase(2'h2, 1'b1, 8'h28, 32'h8000_0000, 1'b0);
    shcase(2'h2, 1'b1, 8'h20, 32'h7FFF_FFFF, 1'b1);
    shcase(2'h3, 1'b1, 8'h20, 32'h8000_0001, 1'b0);
    shcase(2'h3, 1'b1, 8'h25, 32'h0000_0031, 1'b0);
    immc(4'h4, 8'hFF, 1'b0);
    immc(4'h0, 8'h81, 1'b1);
    immc(4'hF, 8'hC1, 1'b0);
    immc(4'h1, 8'hA7, 1'b1);
  endtask

  task automatic control_tests();
    exec(32'hE1B0100F, 32'h0, 32'h0, 32'h0000_00D3, 32'h0);
    chk(op2, 32'h0000_0108);
    exec(32'hE1B0141F, 32'h0, 32'h0, 32'h0000_00D3, 32'h0);
    chk(op2, 32'h0000_010C);
    exec(32'hE1A0F002, 32'h2000, 32'h0, 32'h2000_00D3, 32'h8000_00D1);
    chk(pcv, 32'h0000_2000);
    chk(cu, 32'h2000_00D3);
    chk(bcnt, 3);
    exec(32'hE1B0F412, 32'h2000, 32'h0, 32'h2000_00D3, 32'h8000_00D1);
    chk(pcv, 32'h0000_2000);
    chk(cu, 32'h8000_00D1);
    chk(bcnt, 4);
    chk(st[13:8], 6'h16);
    exec(32'hE1B01002, 32'h0055, 32'h0, 32'h0000_00D3, 32'h0);
    exec(32'hE1111002, 32'h000F, 32'h0, 32'h0000_00D3, 32'h0);
    chk(res, 32'h0000_0055);
    chk(st[ST_RDWR], 1'b0);
    chk(cu[FLAG_Z], 1'b1);
    exec(32'hE133F002, 32'h0, 32'h0, 32'h0000_00D3, 32'h4000_00D1);
    chk(cu, 32'h4000_00D1);
    exec(32'hE133F002, 32'h0, 32'h0, 32'h0000_0010, 32'h4000_00D1);
    chk(cu, 32'h0000_0010);
    exec(32'hE1B01492, 32'h7, 32'h1, 32'h0000_00D3, 32'h0);
    chk(st[ST_UNDEF], 1'b1);
    chk(bcnt, 0);
    chk(res, 32'h0000_0055);
    exec(32'hE1B01F12, 32'h7, 32'h1, 32'h0000_00D3, 32'h0);
    chk(st[ST_BADRS], 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    chk(o_waitrequest, 1'b1);
    chk(o_busy, 1'b0);
    bus(1'b0, OFS_CUR, 32'h0000_0000);
    chk(q, RST_CUR);
    bus(1'b1, OFS_RESULT, 32'hFFFF_FFFF);
    bus(1'b0, OFS_RESULT, 32'h0000_0000);
    chk(q, RST_WORD);
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // partial write: only lanes 0 and 2 may change
    bus(1'b1, OFS_OPA, 32'hFFFF_FFFF);
    i_byteenable <= 4'h5;
    bus(1'b1, OFS_OPA, 32'h1234_5678);
    i_byteenable <= 4'hF;
    bus(1'b0, OFS_OPA, 32'h0000_0000);
    chk(q, 32'hFF34_FF78);
    shift_tests();
    control_tests();
    complete_run();
  end

  // generous bound: the full run needs about 1600 cycles
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
endmodule
